// File: inc/stcm_pkg.sv
// constants shared by the serial text capture monitor
package stcm_pkg;
    // ---------------------------------------------------------------
    // clocking and stimulus timing
    // ---------------------------------------------------------------
    localparam int unsigned MCLK_HZ        = 200_000_000;
    localparam int unsigned MCLK_PERIOD_PS = 5000;
    localparam int unsigned XTAL_HZ        = 50_000_000;
    // half period of the crystal clock in mclk cycles, rounded down, at least one
    localparam int unsigned XTAL_HALF_CYC  = (MCLK_HZ / (2 * XTAL_HZ)) < 1 ? 1 : MCLK_HZ / (2 * XTAL_HZ);
    localparam int unsigned RST_LOW_NS     = 5;
    // least hold time rounds up to whole cycles, at least one
    localparam int unsigned RST_LOW_CYC_I  = (RST_LOW_NS * 1000 + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
    localparam int unsigned RST_LOW_CYC    = RST_LOW_CYC_I < 1 ? 1 : RST_LOW_CYC_I;

    // ---------------------------------------------------------------
    // character framing and special codes
    // ---------------------------------------------------------------
    localparam int unsigned DATA_BITS   = 8;
    localparam logic [7:0]  CHAR_CR     = 8'h0D;
    localparam logic [7:0]  CHAR_EOT    = 8'h04;
    localparam logic [7:0]  CHAR_ESC    = 8'h1B;
    localparam logic [2:0]  LAST_BIT    = 3'h7;

    // ---------------------------------------------------------------
    // line buffer
    // ---------------------------------------------------------------
    localparam int unsigned LINE_DEPTH  = 64;
    localparam int unsigned IDX_W       = 6;
    localparam int unsigned LEN_W       = 7;
    localparam logic [6:0]  LINE_FULL   = 7'h40;

    typedef enum logic [1:0] {
        STCM_RX_IDLE = 2'b00,
        STCM_RX_DATA = 2'b01,
        STCM_RX_STOP = 2'b10
    } stcm_rx_t;

    typedef enum logic [0:0] {
        STCM_EM_IDLE = 1'b0,
        STCM_EM_SEND = 1'b1
    } stcm_em_t;
endpackage

// File: logic/stcm_monitor.sv
// serial text capture monitor with clock, reset and crossover stimulus
`timescale 1ns/1ps

// Contract
// - the serial input is sampled at one data bit per mclk cycle, so another line speed needs another clock.
// - received characters are collected and the collected line is sent out as a message on carriage return.
// - a received 0x04 halts the run unless it directly follows an escape character 0x1B that is not itself escaped.
// - a single-cycle completion pulse is driven just before the halt takes effect.
// - the active-low system reset is held low for 5 ns after start and then released.
// - the first and second serial ports are cross-connected, transmit of each to receive of the other.
module stcm_monitor
    import stcm_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       srst,
    input  wire logic       serial_port_third_txd,
    input  wire logic       serial_port_first_txd,
    input  wire logic       serial_port_second_txd,
    input  wire logic       msg_ready,
    output logic            serial_port_first_rxd,
    output logic            serial_port_second_rxd,
    output logic            crystal_clock_in,
    output logic            system_reset_low,
    output logic [7:0]      msg_data,
    output logic            msg_last,
    output logic            msg_valid,
    output logic            sim_finish_pulse,
    output logic            sim_halt,
    output logic            frame_error,
    output logic            line_dropped
);

    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    stcm_rx_t         rx_state_r;
    logic [2:0]       bit_cnt_r;
    logic [7:0]       shift_r;
    logic             char_stb_r;
    logic [7:0]       char_r;
    logic             esc_r;
    logic             finish_r;
    logic             halt_r;
    logic             ferr_r;
    logic             drop_r;
    logic [7:0]       line_mem [LINE_DEPTH];
    logic [LEN_W-1:0] len_r;
    logic [IDX_W-1:0] rd_idx_r;
    stcm_em_t         em_state_r;
    logic [7:0]       out_data_r;
    logic             out_last_r;
    logic             out_v_r;
    logic [7:0]       skid_data_r;
    logic             skid_last_r;
    logic             skid_v_r;
    logic             push_v;
    logic             push_rdy;
    logic             push_fire;
    logic             push_last;
    logic [7:0]       push_data;
    logic             is_eot;
    logic             is_cr;
    logic [1:0]       xtal_cnt_r;
    logic             xtal_r;
    logic [3:0]       rst_cnt_r;
    logic             rst_low_r;
    logic             p1_rxd_r;
    logic             p2_rxd_r;

    // ---------------------------------------------------------------
    // serial receiver
    // ---------------------------------------------------------------
    // one bit per cycle: no oversampling, the line is read on every rising edge
    // start, eight data lsb first, stop
    always_ff @(posedge mclk) begin
        if (srst) begin
            rx_state_r <= STCM_RX_IDLE;
            bit_cnt_r  <= 3'h0;
            shift_r    <= 8'h00;
            char_stb_r <= 1'b0;
            char_r     <= 8'h00;
            ferr_r     <= 1'b0;
        end else begin
            char_stb_r <= 1'b0;
            case (rx_state_r)
                STCM_RX_IDLE: begin
                    // once halted the line is no longer watched
                    if (!halt_r && !finish_r && !serial_port_third_txd) begin
                        rx_state_r <= STCM_RX_DATA;
                        bit_cnt_r  <= 3'h0;
                    end
                end
                STCM_RX_DATA: begin
                    shift_r   <= {serial_port_third_txd, shift_r[7:1]};
                    bit_cnt_r <= bit_cnt_r + 3'h1;
                    if (bit_cnt_r == LAST_BIT) begin
                        rx_state_r <= STCM_RX_STOP;
                    end
                end
                STCM_RX_STOP: begin
                    rx_state_r <= STCM_RX_IDLE;
                    // a low stop bit marks a broken frame; the character is thrown away
                    if (serial_port_third_txd) begin
                        char_stb_r <= 1'b1;
                        char_r     <= shift_r;
                    end else begin
                        ferr_r <= 1'b1;
                    end
                end
                default: begin
                    rx_state_r <= STCM_RX_IDLE;
                end
            endcase
        end
    end

    assign is_eot = char_stb_r && (char_r == CHAR_EOT) && !esc_r;
    assign is_cr  = char_stb_r && (char_r == CHAR_CR);

    // ---------------------------------------------------------------
    // escape and end of run
    // ---------------------------------------------------------------
    // escape pending lasts exactly one character
    always_ff @(posedge mclk) begin
        if (srst) begin
            esc_r <= 1'b0;
        end else if (char_stb_r) begin
            esc_r <= esc_r ? 1'b0 : (char_r == CHAR_ESC);
        end
    end

    // unescaped end code halts; pulse one cycle ahead of the halt level
    always_ff @(posedge mclk) begin
        if (srst) begin
            finish_r <= 1'b0;
            halt_r   <= 1'b0;
        end else begin
            finish_r <= is_eot && !halt_r && !finish_r;
            halt_r   <= halt_r | finish_r;
        end
    end

    // ---------------------------------------------------------------
    // line buffer and message emitter
    // ---------------------------------------------------------------
    assign push_v    = (em_state_r == STCM_EM_SEND);
    assign push_rdy  = !skid_v_r;
    assign push_fire = push_v && push_rdy;
    assign push_data = line_mem[rd_idx_r];
    assign push_last = ({1'b0, rd_idx_r} == (len_r - 7'h01));

    // characters other than an unescaped 0x04 arriving while a line drains are dropped rather than stalling the link,
    // because the transmitter cannot be held off
    // gather until carriage return, then send the line
    always_ff @(posedge mclk) begin
        if (srst) begin
            em_state_r <= STCM_EM_IDLE;
            len_r      <= '0;
            rd_idx_r   <= '0;
            drop_r     <= 1'b0;
        end else begin
            case (em_state_r)
                STCM_EM_IDLE: begin
                    if (is_cr && len_r != '0) begin
                        em_state_r <= STCM_EM_SEND;
                        rd_idx_r   <= '0;
                    end else if (char_stb_r && !is_cr && !is_eot) begin
                        if (len_r == LINE_FULL) begin
                            drop_r <= 1'b1;
                        end else begin
                            line_mem[len_r[IDX_W-1:0]] <= char_r;
                            len_r                      <= len_r + 7'h01;
                        end
                    end
                end
                STCM_EM_SEND: begin
                    if (char_stb_r && !is_eot) begin
                        drop_r <= 1'b1;
                    end
                    if (push_fire) begin
                        if (push_last) begin
                            em_state_r <= STCM_EM_IDLE;
                            len_r      <= '0;
                        end else begin
                            rd_idx_r <= rd_idx_r + 6'h01;
                        end
                    end
                end
                default: begin
                    em_state_r <= STCM_EM_IDLE;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // two-entry output buffer
    // ---------------------------------------------------------------
    // the skid entry absorbs the word in flight when the receiver stalls, so nothing is lost
    always_ff @(posedge mclk) begin
        if (srst) begin
            out_v_r     <= 1'b0;
            out_data_r  <= 8'h00;
            out_last_r  <= 1'b0;
            skid_v_r    <= 1'b0;
            skid_data_r <= 8'h00;
            skid_last_r <= 1'b0;
        end else if (out_v_r && msg_ready) begin
            if (skid_v_r) begin
                out_data_r <= skid_data_r;
                out_last_r <= skid_last_r;
                skid_v_r   <= 1'b0;
            end else if (push_fire) begin
                out_data_r <= push_data;
                out_last_r <= push_last;
            end else begin
                out_v_r <= 1'b0;
            end
        end else if (!out_v_r) begin
            if (push_fire) begin
                out_v_r    <= 1'b1;
                out_data_r <= push_data;
                out_last_r <= push_last;
            end
        end else if (push_fire) begin
            skid_v_r    <= 1'b1;
            skid_data_r <= push_data;
            skid_last_r <= push_last;
        end
    end

    // ---------------------------------------------------------------
    // clock, reset and crossover stimulus
    // ---------------------------------------------------------------
    // crystal clock from a divider, one toggle per half period
    always_ff @(posedge mclk) begin
        if (srst) begin
            xtal_cnt_r <= 2'h0;
            xtal_r     <= 1'b0;
        end else if (xtal_cnt_r == 2'(XTAL_HALF_CYC - 1)) begin
            xtal_cnt_r <= 2'h0;
            xtal_r     <= ~xtal_r;
        end else begin
            xtal_cnt_r <= xtal_cnt_r + 2'h1;
        end
    end

    // hold the system reset low for the set time, then release for good
    always_ff @(posedge mclk) begin
        if (srst) begin
            rst_cnt_r <= 4'h0;
            rst_low_r <= 1'b0;
        end else if (rst_cnt_r == 4'(RST_LOW_CYC - 1)) begin
            rst_low_r <= 1'b1;
        end else begin
            rst_cnt_r <= rst_cnt_r + 4'h1;
        end
    end

    // each transmit line drives the other port's receive line; idle high in reset
    always_ff @(posedge mclk) begin
        if (srst) begin
            p1_rxd_r <= 1'b1;
            p2_rxd_r <= 1'b1;
        end else begin
            p1_rxd_r <= serial_port_second_txd;
            p2_rxd_r <= serial_port_first_txd;
        end
    end

    // ---------------------------------------------------------------
    // outputs, all from flip-flops
    // ---------------------------------------------------------------
    assign serial_port_first_rxd  = p1_rxd_r;
    assign serial_port_second_rxd = p2_rxd_r;
    assign crystal_clock_in       = xtal_r;
    assign system_reset_low       = rst_low_r;
    assign msg_data               = out_data_r;
    assign msg_last               = out_last_r;
    assign msg_valid              = out_v_r;
    assign sim_finish_pulse       = finish_r;
    assign sim_halt               = halt_r;
    assign frame_error            = ferr_r;
    assign line_dropped           = drop_r;

endmodule

// File: verification/stcm_monitor_chk.sv
// port-level assertions for the serial text capture monitor
`timescale 1ns/1ps
module stcm_monitor_chk (
    input wire logic       mclk,
    input wire logic       srst,
    input wire logic       serial_port_first_txd,
    input wire logic       serial_port_second_txd,
    input wire logic       serial_port_first_rxd,
    input wire logic       serial_port_second_rxd,
    input wire logic       crystal_clock_in,
    input wire logic       system_reset_low,
    input wire logic [7:0] msg_data,
    input wire logic       msg_last,
    input wire logic       msg_valid,
    input wire logic       msg_ready,
    input wire logic       sim_finish_pulse,
    input wire logic       sim_halt
);
    // ---------------------------------------------------------------
    // one clock domain, so one default clocking and disable
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    a_cross_first: assert property (!$past(srst) |-> serial_port_second_rxd == $past(serial_port_first_txd))
        else $error("second port receive is not the delayed first transmit");
    a_cross_second: assert property (!$past(srst) |-> serial_port_first_rxd == $past(serial_port_second_txd))
        else $error("first port receive is not the delayed second transmit");
    a_xtal_half: assert property ($changed(crystal_clock_in) |=> $stable(crystal_clock_in) ##1 $changed(crystal_clock_in))
        else $error("crystal clock half period is not two cycles");
    a_rst_release: assert property ($fell(srst) |-> !system_reset_low ##1 system_reset_low)
        else $error("system reset not released one cycle after start");
    a_rst_hold: assert property (system_reset_low |=> system_reset_low)
        else $error("system reset asserted again without srst");
    a_pulse_once: assert property (sim_finish_pulse |=> !sim_finish_pulse && sim_halt)
        else $error("finish pulse longer than one cycle or no halt after it");
    a_halt_stays: assert property (sim_halt |=> sim_halt && !sim_finish_pulse)
        else $error("halt dropped or a second finish pulse");
    a_msg_hold: assert property (msg_valid && !msg_ready |=> msg_valid && $stable(msg_data) && $stable(msg_last))
        else $error("message word changed while stalled");
endmodule

bind stcm_monitor stcm_monitor_chk u_chk (.mclk, .srst, .serial_port_first_txd, .serial_port_second_txd,
    .serial_port_first_rxd, .serial_port_second_rxd, .crystal_clock_in, .system_reset_low, .msg_data,
    .msg_last, .msg_valid, .msg_ready, .sim_finish_pulse, .sim_halt);

// File: verification/stcm_monitor_tb.sv
// self-checking bench for the serial text capture monitor
`timescale 1ns/1ps
module stcm_monitor_tb
    import stcm_pkg::*;
;
    logic       mclk                   = 1'b0;
    logic       srst                   = 1'b1;
    logic       serial_port_first_txd  = 1'b1;
    logic       serial_port_second_txd = 1'b1;
    logic       msg_ready              = 1'b0;
    logic       tx_go                  = 1'b0;
    logic [7:0] tx_byte                = 8'h00;
    logic       tx_bad_stop            = 1'b0;
    logic       serial_port_third_txd, tx_busy, serial_port_first_rxd, serial_port_second_rxd;
    logic       crystal_clock_in, system_reset_low, msg_last, msg_valid;
    logic       sim_finish_pulse, sim_halt, frame_error, line_dropped;
    logic [7:0] msg_data;
    int         n_fail      = 0;
    int         checks_done = 0;
    int         cyc         = 0;

    // ---------------------------------------------------------------
    // clock and instances
    // ---------------------------------------------------------------
    always #2.5 mclk = ~mclk;
    stcm_monitor DUT (.mclk, .srst, .serial_port_third_txd, .serial_port_first_txd, .serial_port_second_txd,
        .msg_ready, .serial_port_first_rxd, .serial_port_second_rxd, .crystal_clock_in, .system_reset_low,
        .msg_data, .msg_last, .msg_valid, .sim_finish_pulse, .sim_halt, .frame_error, .line_dropped);
    stcm_tx_model u_tx (.mclk, .srst, .tx_go, .tx_byte, .tx_bad_stop, .tx_busy, .txd(serial_port_third_txd));

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // waits for the transmitter to be free, so characters never overlap
    task automatic send_char(input logic [7:0] b);
        @(posedge mclk);
        while (tx_busy) @(posedge mclk);
        tx_go   <= 1'b1;
        tx_byte <= b;
        @(posedge mclk);
        tx_go   <= 1'b0;
    endtask

    task automatic get_word(input logic [7:0] exp, input logic lst);
        int n;
        n = 0;
        @(posedge mclk);
        while (!(msg_valid === 1'b1 && msg_ready === 1'b1) && n < 400) begin
            n++;
            @(posedge mclk);
        end
        check({7'h00, msg_valid}, 8'h01);
        check(msg_data, exp);
        check({7'h00, msg_last}, {7'h00, lst});
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_cross();
        for (int v = 0; v < 2; v++) begin
            serial_port_first_txd  <= v[0];
            serial_port_second_txd <= ~v[0];
            repeat (2) @(posedge mclk);
            check({7'h00, serial_port_second_rxd}, {7'h00, v[0]});
            check({7'h00, serial_port_first_rxd}, {7'h00, ~v[0]});
        end
        check({7'h00, system_reset_low}, 8'h01);
    endtask

    // empty line first, then a stalled three-character line; a character sent while it drains is lost
    task automatic t_line();
        msg_ready <= 1'b0;
        send_char(CHAR_CR);
        send_char(8'h41);
        send_char(8'h42);
        send_char(8'h43);
        send_char(CHAR_CR);
        check({7'h00, line_dropped}, 8'h00);
        send_char(8'h44);
        repeat (20) @(posedge mclk);
        check({7'h00, msg_valid}, 8'h01);
        check({7'h00, line_dropped}, 8'h01);
        msg_ready <= 1'b1;
        get_word(8'h41, 1'b0);
        get_word(8'h42, 1'b0);
        get_word(8'h43, 1'b1);
        @(posedge mclk);
        check({7'h00, msg_valid}, 8'h00);
    endtask

    task automatic t_escape();
        send_char(CHAR_ESC);
        send_char(CHAR_EOT);
        send_char(8'h5A);
        send_char(CHAR_CR);
        get_word(CHAR_ESC, 1'b0);
        get_word(CHAR_EOT, 1'b0);
        get_word(8'h5A, 1'b1);
        check({7'h00, sim_halt}, 8'h00);
    endtask

    // a low stop bit throws the character away and flags the frame
    task automatic t_frame();
        check({7'h00, frame_error}, 8'h00);
        tx_bad_stop <= 1'b1;
        send_char(8'h58);
        tx_bad_stop <= 1'b0;
        repeat (12) @(posedge mclk);
        check({7'h00, frame_error}, 8'h01);
        send_char(8'h59);
        send_char(CHAR_CR);
        get_word(8'h59, 1'b1);
    endtask

    // second escape only clears pending, so the end code must halt
    task automatic t_halt();
        int n;
        n = 0;
        send_char(CHAR_ESC);
        send_char(CHAR_ESC);
        send_char(CHAR_EOT);
        while (sim_finish_pulse !== 1'b1 && n < 40) begin
            n++;
            @(posedge mclk);
        end
        check({7'h00, sim_finish_pulse}, 8'h01);
        @(posedge mclk);
        check({7'h00, sim_halt}, 8'h01);
        send_char(8'h51);
        send_char(CHAR_CR);
        repeat (30) @(posedge mclk);
        check({7'h00, msg_valid}, 8'h00);
    endtask

    // ---------------------------------------------------------------
    // main sequence and hang guard
    // ---------------------------------------------------------------
    initial begin
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        repeat (3) @(posedge mclk);
        t_cross();
        t_line();
        t_escape();
        t_frame();
        t_halt();
        stop_test();
    end

    // the whole run needs well under a thousand cycles
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            stop_test();
        end
    end
endmodule

// File: verification/stcm_tx_model.sv
// fast test-mode serial transmitter that feeds the monitor
`timescale 1ns/1ps
module stcm_tx_model (
    input  wire logic       mclk,
    input  wire logic       srst,
    input  wire logic       tx_go,
    input  wire logic [7:0] tx_byte,
    input  wire logic       tx_bad_stop,
    output logic            tx_busy,
    output logic            txd
);
    logic [9:0] shift_r;
    logic [3:0] left_r;

    // start, lsb first, stop, idle high
    always_ff @(posedge mclk) begin
        if (srst) begin
            shift_r <= 10'h3FF;
            left_r  <= 4'h0;
        end else if (tx_go && left_r == 4'h0) begin
            // a broken stop bit is sent low on request, to exercise the frame check
            shift_r <= {~tx_bad_stop, tx_byte, 1'b0};
            left_r  <= 4'hA;
        end else if (left_r != 4'h0) begin
            shift_r <= {1'b1, shift_r[9:1]}; // ones refill, so the line idles high
            left_r  <= left_r - 4'h1;
        end
    end

    // busy covers the stop bit, so a new start never clips it
    assign txd     = shift_r[0];
    assign tx_busy = (left_r != 4'h0);
endmodule
